//--- inc/ilpe_consts.svh
// Constants for the interrupt and low-power entry controller
`ifndef ILPE_CONSTS_SVH
`define ILPE_CONSTS_SVH
// Register indices (word address = index)
`define ILPE_A_STATUS 4'h0
`define ILPE_A_MASK 4'h1
`define ILPE_A_CTRL 4'h2
`define ILPE_A_POL 4'h3
`define ILPE_A_INFO 4'h4
`define ILPE_A_SP 4'h5
`define ILPE_A_LVL 4'h6
`define ILPE_A_PEND 4'h7
// First per-source control register
`define ILPE_A_SRC 4'h8
// Stack pointer value at reset
`define ILPE_SP_RST 16'h0000
// Control register bit positions
`define ILPE_C_GIE 0
`define ILPE_C_WAIT 1
`define ILPE_C_STOP 2
// Per-source control bit positions
`define ILPE_F_EN 3
`define ILPE_F_REQ 4
// Status register bit positions
`define ILPE_S_TAKE 0
`define ILPE_S_NMI 1
`define ILPE_S_WAKE 2
// Instruction-queue bytes needed before halting
`define ILPE_PREFETCH 3'h4
// Cycles the enable write is held off behind a control write
`define ILPE_GIE_DLY 3'h2
`define ILPE_GIE_DLY_HOLD 3'h4
`endif

//--- inc/ilpe_pkg.sv
// Types for the interrupt and low-power entry controller
package ilpe_pkg;
	typedef enum logic [1:0] {
		ILPE_RUN = 2'b00,
		ILPE_FILL = 2'b01,
		ILPE_WAIT = 2'b10,
		ILPE_STOP = 2'b11
	} ilpe_pwr_type;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ilpe_bus_type;
	typedef struct packed {
		logic [2:0] num;
		logic [2:0] lvl;
	} ilpe_info_type;
endpackage

//--- rtl/ilpe_ctrl.sv
// Interrupt acceptance and low-power entry controller
`timescale 1ns/10ps
`include "ilpe_consts.svh"
module ilpe_ctrl #(
	parameter int NSRC = 6
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Interrupt sources and bus hold
	input wire logic [NSRC-1:0] i_external_irq_pins,
	input wire logic i_nmi_n,
	input wire logic i_bus_hold,
	// Core side
	input wire logic i_ack,
	input wire logic i_fetch_byte,
	output logic o_irq,
	output logic o_nmi,
	output logic [5:0] o_info,
	output logic o_halt,
	output logic o_clk_stop,
	output logic o_int
);
	// ==========================================================
	// Bus decode
	ilpe_pkg::ilpe_bus_type bus;
	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	logic [NSRC-1:0] req_q, req_d, pol_q, pol_d, pin_q, pin_d;
	logic [NSRC-1:0] en_q, en_d;
	logic [2:0] lvl_q [NSRC];
	logic [2:0] lvl_d [NSRC];
	logic [15:0] sp_q, sp_d, rdata_q, rdata_d;
	logic [2:0] st_q, st_d, msk_q, msk_d;
	logic gie_q, gie_d, nmi_q, nmi_d;
	logic [2:0] dly_q, dly_d, cnt_q, cnt_d;
	logic gie_pend_q, gie_pend_d;
	ilpe_pkg::ilpe_pwr_type pwr_q, pwr_d;
	ilpe_pkg::ilpe_info_type best;
	logic best_v, irq_d, int_d;
	logic [NSRC-1:0] edge_hit;
	logic stop_sel_q, stop_sel_d, wake_req;

	// ==========================================================
	// Priority pick: highest level, lowest index on ties
	always_comb
	begin
		best = '{num: 3'h0, lvl: 3'h0};
		best_v = 1'b0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (req_q[i] && en_q[i] && (!best_v || lvl_q[i] > best.lvl))
			begin
				best = '{num: 3'(i), lvl: lvl_q[i]};
				best_v = 1'b1;
			end
		end
	end

	// Active edge per pin after polarity selection
	// Previous sample inactive, present sample active
	assign edge_hit = ~(pin_q ^ pol_q) & (i_external_irq_pins ^ pol_q);

	// ==========================================================
	// Request, control and software registers
	always_comb
	begin
		req_d = req_q;
		pol_d = pol_q;
		en_d = en_q;
		lvl_d = lvl_q;
		sp_d = sp_q;
		msk_d = msk_q;
		gie_d = gie_q;
		gie_pend_d = gie_pend_q;
		dly_d = dly_q;
		pin_d = i_external_irq_pins;
		rdata_d = 16'h0000;
		// Ack fetch or software info read clears chosen bit
		if ((i_ack || (bus.rd && bus.addr == `ILPE_A_INFO)) && best_v)
			req_d[best.num] = 1'b0;
		// Queue delay runs every cycle; a control write reloads it below
		if (dly_q != 3'h0)
			dly_d = dly_q - 3'h1;
		if (dly_q == 3'h1 && gie_pend_q)
		begin
			gie_d = 1'b1;
			gie_pend_d = 1'b0;
		end
		if (bus.wr)
		begin
			unique case (bus.addr)
				`ILPE_A_MASK: msk_d = bus.wdata[2:0];
				`ILPE_A_CTRL:
				begin
					// Enable set waits out the queue delay
					if (bus.wdata[`ILPE_C_GIE] && !gie_q && dly_q > 3'h1)
						gie_pend_d = 1'b1;
					else
					begin
						gie_d = bus.wdata[`ILPE_C_GIE];
						gie_pend_d = 1'b0;
					end
				end
				`ILPE_A_POL: pol_d = bus.wdata[NSRC-1:0];
				`ILPE_A_SP: sp_d = bus.wdata;
				`ILPE_A_PEND: req_d = req_d & bus.wdata[NSRC-1:0];
				default:
				begin
					// Per-source control: level, enable, request
					if (bus.addr >= `ILPE_A_SRC &&
						int'(bus.addr) < int'(`ILPE_A_SRC) + NSRC)
					begin
						en_d[bus.addr[2:0]] = bus.wdata[`ILPE_F_EN];
						lvl_d[bus.addr[2:0]] = bus.wdata[2:0];
						req_d[bus.addr[2:0]] = bus.wdata[`ILPE_F_REQ];
						dly_d = i_bus_hold ? `ILPE_GIE_DLY_HOLD
							: `ILPE_GIE_DLY;
					end
				end
			endcase
		end
		// Edges set last so they win over any write clear
		req_d = req_d | edge_hit;
		if (bus.rd)
		begin
			unique case (bus.addr)
				`ILPE_A_STATUS: rdata_d = {13'h0000, st_q};
				`ILPE_A_MASK: rdata_d = {13'h0000, msk_q};
				`ILPE_A_CTRL: rdata_d = {13'h0000, pwr_q == ilpe_pkg::ILPE_STOP,
					pwr_q == ilpe_pkg::ILPE_WAIT, gie_q};
				`ILPE_A_POL: rdata_d = 16'(pol_q);
				`ILPE_A_INFO: rdata_d = {10'h000, best.lvl, best.num};
				`ILPE_A_SP: rdata_d = sp_q;
				`ILPE_A_PEND: rdata_d = 16'(req_q);
				default:
				begin
					if (bus.addr >= `ILPE_A_SRC &&
						int'(bus.addr) < int'(`ILPE_A_SRC) + NSRC)
						rdata_d = {11'h000, req_q[bus.addr[2:0]],
							en_q[bus.addr[2:0]], lvl_q[bus.addr[2:0]]};
				end
			endcase
		end
	end

	// ==========================================================
	// Power state: fill the queue, then halt
	always_comb
	begin
		pwr_d = pwr_q;
		cnt_d = cnt_q;
		unique case (pwr_q)
			ilpe_pkg::ILPE_RUN:
			begin
				if (bus.wr && bus.addr == `ILPE_A_CTRL &&
					(bus.wdata[`ILPE_C_WAIT] || bus.wdata[`ILPE_C_STOP]))
				begin
					pwr_d = ilpe_pkg::ILPE_FILL;
					cnt_d = 3'h0;
				end
			end
			ilpe_pkg::ILPE_FILL:
			begin
				if (i_fetch_byte)
					cnt_d = cnt_q + 3'h1;
				if (cnt_q == `ILPE_PREFETCH)
					pwr_d = stop_sel_q ? ilpe_pkg::ILPE_STOP
						: ilpe_pkg::ILPE_WAIT;
			end
			ilpe_pkg::ILPE_WAIT, ilpe_pkg::ILPE_STOP:
			begin
				if (wake_req)
					pwr_d = ilpe_pkg::ILPE_RUN;
			end
		endcase
	end

	// Remember which low-power mode was asked for
	assign stop_sel_d = (pwr_q == ilpe_pkg::ILPE_RUN && bus.wr &&
		bus.addr == `ILPE_A_CTRL) ? bus.wdata[`ILPE_C_STOP] : stop_sel_q;
	// Any enabled request while the global enable is set, or the non-maskable pin, wakes the core
	assign wake_req = (best_v && gie_q) || !i_nmi_n;

	// ==========================================================
	// Events, status and outputs
	always_comb
	begin
		// Non-maskable level is not gated by any enable
		nmi_d = !i_nmi_n;
		st_d = st_q;
		if (bus.rd && bus.addr == `ILPE_A_STATUS)
			st_d = 3'h0;
		st_d[`ILPE_S_TAKE] = st_d[`ILPE_S_TAKE] | i_ack;
		st_d[`ILPE_S_NMI] = st_d[`ILPE_S_NMI] | (!i_nmi_n && !nmi_q);
		st_d[`ILPE_S_WAKE] = st_d[`ILPE_S_WAKE] |
			((pwr_q == ilpe_pkg::ILPE_WAIT || pwr_q == ilpe_pkg::ILPE_STOP)
			&& pwr_d == ilpe_pkg::ILPE_RUN);
		irq_d = best_v && gie_d;
		int_d = |(st_d & msk_d);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			req_q <= '0;
			pol_q <= '0;
			pin_q <= '0;
			en_q <= '0;
			for (int i = 0; i < NSRC; i++)
				lvl_q[i] <= 3'h0;
			sp_q <= `ILPE_SP_RST;
			st_q <= 3'h0;
			msk_q <= 3'h0;
			gie_q <= 1'b0;
			gie_pend_q <= 1'b0;
			dly_q <= 3'h0;
			nmi_q <= 1'b0;
			cnt_q <= 3'h0;
			pwr_q <= ilpe_pkg::ILPE_RUN;
			stop_sel_q <= 1'b0;
			rdata_q <= 16'h0000;
			o_irq <= 1'b0;
			o_nmi <= 1'b0;
			o_info <= 6'h00;
			o_halt <= 1'b0;
			o_clk_stop <= 1'b0;
			o_int <= 1'b0;
		end
		else
		begin
			req_q <= req_d;
			pol_q <= pol_d;
			pin_q <= pin_d;
			en_q <= en_d;
			lvl_q <= lvl_d;
			sp_q <= sp_d;
			st_q <= st_d;
			msk_q <= msk_d;
			gie_q <= gie_d;
			gie_pend_q <= gie_pend_d;
			dly_q <= dly_d;
			nmi_q <= nmi_d;
			cnt_q <= cnt_d;
			pwr_q <= pwr_d;
			stop_sel_q <= stop_sel_d;
			rdata_q <= rdata_d;
			o_irq <= irq_d;
			o_nmi <= nmi_d;
			o_info <= {best.lvl, best.num};
			o_halt <= pwr_d == ilpe_pkg::ILPE_WAIT ||
				pwr_d == ilpe_pkg::ILPE_STOP;
			o_clk_stop <= pwr_d == ilpe_pkg::ILPE_STOP;
			o_int <= int_d;
		end
	end
	assign o_rdata = rdata_q;

	// ==========================================================
	// Checks
	sp_reset_a: assert property (@(posedge i_clk)
		!i_rst_n |=> sp_q == 16'h0000)
		else $error("stack pointer not zero after reset");
	ack_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ack && best_v && !edge_hit[best.num]) |=>
		!req_q[$past(best.num)])
		else $error("acknowledged request not cleared");
	info_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(bus.rd && bus.addr == `ILPE_A_INFO && best_v &&
		!edge_hit[best.num] && !bus.wr) |=> !req_q[$past(best.num)])
		else $error("info read did not clear request");
	nmi_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_nmi_n |=> o_nmi)
		else $error("non-maskable input blocked");
	edge_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		edge_hit != '0 |=> (req_q & $past(edge_hit)) == $past(edge_hit))
		else $error("request lost on control write");
	gie_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(dly_q > 3'h1) |=> $stable(gie_q) || !gie_q)
		else $error("enable set inside queue delay");
	halt_fill_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(pwr_q == ilpe_pkg::ILPE_FILL && pwr_d != ilpe_pkg::ILPE_FILL) |->
		cnt_q == `ILPE_PREFETCH)
		else $error("halted before four bytes fetched");
	halt_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		pwr_q == ilpe_pkg::ILPE_STOP |-> o_halt && o_clk_stop)
		else $error("stop state without halt outputs");
endmodule

//--- sim/ilpe_core_model.sv
// Core sequencer model: takes interrupts and prefetches bytes
`timescale 1ns/10ps
module ilpe_core_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// From the controller
	input wire logic i_irq,
	// Bench commands
	input wire logic [2:0] i_fetch_n,
	input wire logic i_fetch_go,
	// To the controller
	output logic o_ack,
	output logic o_fetch_byte
);
	logic [2:0] left_q;
	logic wait_q;
	// ====
	// One ack per request; waits for the line to drop so a slow
	// clear is never taken twice
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_ack <= 1'h0;
			wait_q <= 1'h0;
		end
		else
		begin
			o_ack <= i_irq && !wait_q && !o_ack;
			wait_q <= i_irq && (wait_q || o_ack);
		end
	end
	// ====
	// Byte prefetch, one pulse a cycle while credit remains
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			left_q <= 3'h0;
		else if (i_fetch_go)
			left_q <= i_fetch_n;
		else if (left_q != 3'h0)
			left_q <= left_q - 3'h1;
		o_fetch_byte <= i_rst_n && (left_q != 3'h0);
	end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the interrupt and low-power controller
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'h0, i_rst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
	logic i_nmi_n = 1'h1, i_bus_hold = 1'h0, fgo = 1'h0, rd_d = 1'h0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic [5:0] pins = 6'h00;
	logic [2:0] fn = 3'h0;
	logic [15:0] o_rdata;
	logic [5:0] o_info;
	logic o_irq, o_nmi, o_halt, o_clk_stop, o_int, ack, fb;
	logic [2:0] lv [6];
	logic [15:0] exp_q [$];
	int err_total = 0, n_checks = 0, seed = 21, bi = 0;
	// ====
	// Clock, device and core model
	always #50 i_clk = ~i_clk;
	ilpe_ctrl #(.NSRC(6)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_external_irq_pins(pins), .i_nmi_n(i_nmi_n),
		.i_bus_hold(i_bus_hold), .i_ack(ack), .i_fetch_byte(fb),
		.o_irq(o_irq), .o_nmi(o_nmi), .o_info(o_info), .o_halt(o_halt),
		.o_clk_stop(o_clk_stop), .o_int(o_int));
	ilpe_core_model u_core (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_irq(o_irq), .i_fetch_n(fn), .i_fetch_go(fgo), .o_ack(ack),
		.o_fetch_byte(fb));
	// ====
	// Tasks
	task automatic check(input logic [15:0] got, input logic [15:0] e);
		n_checks++;
		if (got !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Strobes drop with an idle edge after, so no double drive
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		i_addr <= a;
		i_rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic pulse(input int i);
		pins[i] <= 1'h1;
		@(posedge i_clk);
		pins[i] <= 1'h0;
		pause(3);
	endtask
	task automatic fetch(input logic [2:0] n);
		fn <= n;
		fgo <= 1'h1;
		@(posedge i_clk);
		fgo <= 1'h0;
		pause(6);
	endtask
	// ====
	// Read data monitor: oldest note against the word after a read
	always @(posedge i_clk)
	begin
		if (rd_d)
			check(o_rdata, exp_q.pop_front());
		rd_d <= i_rd;
	end
	// Watchdog, far beyond the under two hundred cycles needed
	initial
	begin
		pause(3000);
		err_total++;
		give_verdict();
	end
	// ====
	// Main sequence
	logic [15:0] spv = 16'h0000;
	initial
	begin
		pause(3);
		i_rst_n <= 1'h1;
		pause(4);
		rd(4'h5, 16'h0000);
		wr(4'h6, 16'hFFFF);
		rd(4'h6, 16'h0000);
		// Random stack pointer, so the later reset check means something
		spv = 16'($random(seed));
		wr(4'h5, spv);
		rd(4'h5, spv);
		// Every source with a random level, global enable off
		for (int i = 0; i < 6; i++)
		begin
			lv[i] = 3'($random(seed));
			wr(4'(8 + i), {12'h000, 1'h1, lv[i]});
			pulse(i);
			rd(4'(8 + i), {11'h000, 2'h3, lv[i]});
			if (lv[i] > lv[bi])
				bi = i;
		end
		check(16'(o_info), {10'h000, lv[bi], 3'(bi)});
		rd(4'h4, {10'h000, lv[bi], 3'(bi)});
		rd(4'(8 + bi), {12'h000, 1'h1, lv[bi]});
		for (int i = 0; i < 6; i++)
			wr(4'(8 + i), 16'h0000);
		// Edge in the same cycle as a clearing control write is kept
		pins[2] <= 1'h1;
		wr(4'hA, 16'h0000);
		pins[2] <= 1'h0;
		rd(4'hA, 16'h0010);
		wr(4'hA, 16'h0000);
		// Core takes one request; the fetch clears it
		i_bus_hold <= 1'h1;
		wr(4'hB, 16'h000B);
		wr(4'h2, 16'h0001);
		rd(4'h2, 16'h0000);
		pulse(3);
		pause(8);
		check(16'(o_irq), 16'h0000);
		rd(4'hB, 16'h000B);
		rd(4'h0, 16'h0001);
		rd(4'h0, 16'h0000);
		wr(4'h2, 16'h0000);
		// Polarity flip, clear; then only the falling edge requests
		wr(4'h3, 16'h0001);
		wr(4'h8, 16'h0008);
		rd(4'h8, 16'h0008);
		pins[0] <= 1'h1;
		pause(2);
		rd(4'h8, 16'h0008);
		pins[0] <= 1'h0;
		pause(2);
		rd(4'h8, 16'h0018);
		// Non-maskable input with everything disabled, then enabled in the mask
		i_nmi_n <= 1'h0;
		pause(3);
		check(16'(o_nmi), 16'h0001);
		check(16'(o_int), 16'h0000);
		wr(4'h1, 16'h0002);
		pause(2);
		check(16'(o_int), 16'h0001);
		rd(4'h0, 16'h0002);
		i_nmi_n <= 1'h1;
		pause(3);
		check(16'(o_int), 16'h0000);
		// Wait entry, readback, then the non-maskable pin wakes it
		wr(4'h2, 16'h0002);
		fetch(3'h4);
		pause(2);
		check(16'(o_halt), 16'h0001);
		check(16'(o_clk_stop), 16'h0000);
		rd(4'h2, 16'h0002);
		i_nmi_n <= 1'h0;
		pause(2);
		check(16'(o_halt), 16'h0000);
		i_nmi_n <= 1'h1;
		pause(2);
		rd(4'h0, 16'h0006);
		// Stop entry needs four prefetched bytes
		wr(4'h2, 16'h0004);
		fetch(3'h3);
		check(16'(o_halt), 16'h0000);
		fetch(3'h1);
		check(16'(o_halt), 16'h0001);
		check(16'(o_clk_stop), 16'h0001);
		i_rst_n <= 1'h0;
		pause(3);
		i_rst_n <= 1'h1;
		pause(2);
		check(16'(o_halt), 16'h0000);
		rd(4'h5, 16'h0000);
		give_verdict();
	end
endmodule
